// [src/fru_consts.svh]
// constant definitions for the file-register unary operation unit
`ifndef FRU_CONSTS_SVH
`define FRU_CONSTS_SVH

`define FRU_DATA_W      8
`define FRU_ADDR_W      7
`define FRU_NUM_REGS    128
`define FRU_ZERO_BYTE   8'h00
`define FRU_ONE_BYTE    8'h01
`define FRU_ACC_RST     8'h00
`define FRU_FLAG_RST    1'b0
`define FRU_DEST_ACC    1'b0
`define FRU_DEST_REG    1'b1

`endif

// [src/fru_pkg.sv]
// types shared by the file-register unary operation unit
package fru_pkg;

    // ****************************************
    // operation codes
    // ****************************************
    typedef enum logic [2:0] {
        FRU_OP_NOP     = 3'h0,
        FRU_OP_INVERT  = 3'h1,
        FRU_OP_CLR_REG = 3'h2,
        FRU_OP_CLR_ACC = 3'h3,
        FRU_OP_DEC     = 3'h4,
        FRU_OP_DEC_SKZ = 3'h5,
        FRU_OP_INC_SKZ = 3'h6
    } fru_op_t;

    // ****************************************
    // execution states, gray coded
    // ****************************************
    typedef enum logic [1:0] {
        FRU_ST_EXEC = 2'b00,
        FRU_ST_SKIP = 2'b01
    } fru_state_t;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        fru_op_t    op;
        logic [6:0] addr;
        logic       dest;
    } fru_instr_t;

    typedef struct packed {
        logic [7:0] value;
        logic       zero;
        logic       upd_zero;
        logic       to_reg;
        logic       to_acc;
        logic       skip;
    } fru_alu_res_t;

endpackage : fru_pkg

// [src/fru_alu.sv]
// combinational result path for the single-operand operations
`timescale 1ns/1ps
`default_nettype none
`include "fru_consts.svh"

module fru_alu (
    // ****************************************
    // operation in
    // ****************************************
    input  wire  fru_pkg::fru_instr_t   i_instr,
    input  wire  logic [7:0]            i_operand,
    // ****************************************
    // result out
    // ****************************************
    output var   fru_pkg::fru_alu_res_t o_res
);
    import fru_pkg::*;

    logic [7:0] val;
    logic       zero;

    always_comb begin
        val = i_operand;
        case (i_instr.op)
            FRU_OP_INVERT:  val = ~i_operand;
            FRU_OP_CLR_REG: val = `FRU_ZERO_BYTE;
            FRU_OP_CLR_ACC: val = `FRU_ZERO_BYTE;
            FRU_OP_DEC:     val = i_operand - `FRU_ONE_BYTE;
            FRU_OP_DEC_SKZ: val = i_operand - `FRU_ONE_BYTE;
            FRU_OP_INC_SKZ: val = i_operand + `FRU_ONE_BYTE;
            default:        val = i_operand;
        endcase
    end

    assign zero = (val == `FRU_ZERO_BYTE);

    always_comb begin
        o_res          = '0;
        o_res.value    = val;
        o_res.zero     = zero;
        case (i_instr.op)
            FRU_OP_INVERT, FRU_OP_DEC: begin
                o_res.upd_zero = 1'b1;
                o_res.to_reg   = (i_instr.dest == `FRU_DEST_REG);
                o_res.to_acc   = (i_instr.dest == `FRU_DEST_ACC);
            end
            FRU_OP_CLR_REG: begin
                o_res.upd_zero = 1'b1;
                o_res.to_reg   = 1'b1;
            end
            FRU_OP_CLR_ACC: begin
                o_res.upd_zero = 1'b1;
                o_res.to_acc   = 1'b1;
            end
            FRU_OP_DEC_SKZ, FRU_OP_INC_SKZ: begin
                // flags untouched on the skip pair
                o_res.to_reg   = (i_instr.dest == `FRU_DEST_REG);
                o_res.to_acc   = (i_instr.dest == `FRU_DEST_ACC);
                o_res.skip     = zero;
            end
            default: begin
                o_res.upd_zero = 1'b0;
            end
        endcase
    end

endmodule : fru_alu
`default_nettype wire

// [src/fru_unit.sv]
// file-register unary operation unit with data registers, accumulator and zero flag
//
// Function
// - invert all bits of the addressed register, write destination, update zero flag
// - destination bit 0 writes the accumulator, 1 writes the addressed register
// - register clear writes zero to the register and sets the zero flag
// - accumulator clear loads zero and sets the zero flag, no operand
// - decrement writes value minus one to destination and updates zero flag
// - decrement-skip keeps flags; zero result turns the next instruction into a nop
// - increment-skip keeps flags; zero result turns the next instruction into a nop
`timescale 1ns/1ps
`default_nettype none
`include "fru_consts.svh"

module fru_unit (
    // ****************************************
    // clock and reset
    // ****************************************
    input  wire  logic                i_clk_sys,
    input  wire  logic                i_rst,
    // ****************************************
    // instruction in, one per cycle
    // ****************************************
    input  wire  logic                i_instr_valid,
    input  wire  fru_pkg::fru_instr_t i_instr,
    // ****************************************
    // register preload and inspection
    // ****************************************
    input  wire  logic                i_load_valid,
    input  wire  logic [6:0]          i_load_addr,
    input  wire  logic [7:0]          i_load_data,
    input  wire  logic [6:0]          i_peek_addr,
    // ****************************************
    // state out
    // ****************************************
    output logic [7:0]                o_acc,
    output logic                      o_zero,
    output logic                      o_skip,
    output logic                      o_done,
    output logic [7:0]                o_result,
    output logic [7:0]                o_peek_data
);
    import fru_pkg::*;

    // ****************************************
    // storage
    // ****************************************
    logic [7:0]   regs_ff [`FRU_NUM_REGS];
    logic [7:0]   acc_ff;
    logic         zero_ff;
    fru_state_t   state_ff;
    fru_state_t   nxt_state;
    logic         done_ff;
    logic         skip_ff;
    logic [7:0]   result_ff;
    logic [7:0]   peek_ff;

    logic         exec;
    logic [7:0]   operand;
    fru_alu_res_t res;
    logic         wr_en;
    logic [6:0]   wr_addr;
    logic [7:0]   wr_data;

    // ****************************************
    // decode helpers
    // ****************************************
    // a nop occupies a slot but reports nothing
    function automatic logic fru_is_op(input fru_op_t op);
        return (op != FRU_OP_NOP);
    endfunction : fru_is_op

    // ****************************************
    // instruction take and operand fetch
    // ****************************************
    // an instruction offered in the skip slot is dropped: that slot is the nop
    assign exec    = i_instr_valid && (state_ff == FRU_ST_EXEC);
    // the array is read combinationally, so each op sees the write of the op before it
    assign operand = regs_ff[i_instr.addr];

    // ****************************************
    // result path
    // ****************************************
    fru_alu u_alu (
        .i_instr   (i_instr),
        .i_operand (operand),
        .o_res     (res)
    );

    // ****************************************
    // skip sequencing
    // ****************************************
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            FRU_ST_EXEC: begin
                if (exec && res.skip) begin
                    nxt_state = FRU_ST_SKIP;
                end
            end
            FRU_ST_SKIP: begin
                // the slot lasts one cycle whatever is offered in it
                nxt_state = FRU_ST_EXEC;
            end
            default: begin
                nxt_state = FRU_ST_EXEC;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_ff <= FRU_ST_EXEC;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // the skip slot flag is its own flop so the output has no decode behind it
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            skip_ff <= `FRU_FLAG_RST;
        end else begin
            skip_ff <= (nxt_state == FRU_ST_SKIP);
        end
    end

    // ****************************************
    // data registers
    // ****************************************
    // one write port: an executing op that targets a register wins, a preload that cycle is lost
    always_comb begin
        wr_en   = 1'b0;
        wr_addr = i_load_addr;
        wr_data = i_load_data;
        if (exec && res.to_reg) begin
            wr_en   = 1'b1;
            wr_addr = i_instr.addr;
            wr_data = res.value;
        end else if (i_load_valid) begin
            wr_en   = 1'b1;
        end
    end

    // ****************************************
    // array storage
    // ****************************************
    // no reset on the array: register contents are undefined until written
    always_ff @(posedge i_clk_sys) begin
        if (wr_en) begin
            regs_ff[wr_addr] <= wr_data;
        end
    end

    // ****************************************
    // accumulator
    // ****************************************
    // the destination select is decoded once in the alu so both targets agree
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            acc_ff <= `FRU_ACC_RST;
        end else if (exec && res.to_acc) begin
            acc_ff <= res.value;
        end
    end

    // ****************************************
    // zero flag
    // ****************************************
    // the skip pair never raises upd_zero, so the flag survives it
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            zero_ff <= `FRU_FLAG_RST;
        end else if (exec && res.upd_zero) begin
            zero_ff <= res.zero;
        end
    end

    // ****************************************
    // completion pulse
    // ****************************************
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            done_ff <= `FRU_FLAG_RST;
        end else begin
            done_ff <= exec && fru_is_op(i_instr.op);
        end
    end

    // ****************************************
    // last result
    // ****************************************
    // held across nops and the skip slot so it always names the last real op
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            result_ff <= `FRU_ZERO_BYTE;
        end else if (exec && fru_is_op(i_instr.op)) begin
            result_ff <= res.value;
        end
    end

    // ****************************************
    // inspection port
    // ****************************************
    // peek shows the array as it stood before this edge, so a write shows one edge later
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            peek_ff <= `FRU_ZERO_BYTE;
        end else begin
            peek_ff <= regs_ff[i_peek_addr];
        end
    end

    assign o_acc       = acc_ff;
    assign o_zero      = zero_ff;
    assign o_skip      = skip_ff;
    assign o_done      = done_ff;
    assign o_result    = result_ff;
    assign o_peek_data = peek_ff;

endmodule : fru_unit
`default_nettype wire

// [verification/fru_unit_assertions.sv]
// assertion checker for the file-register unary operation unit
`timescale 1ns/1ps
`default_nettype none
module fru_chk import fru_pkg::*; (
    input wire logic                i_clk_sys, i_rst, i_instr_valid, i_load_valid,
    input wire fru_pkg::fru_instr_t i_instr,
    input wire logic [6:0]          i_load_addr, i_peek_addr,
    input wire logic [7:0]          i_load_data, o_acc, o_result, o_peek_data,
    input wire logic                o_zero, o_skip, o_done
);
    // ****************************************
    // helpers
    // ****************************************
    logic tk, skz, wr;
    assign tk  = i_instr_valid && !o_skip;
    assign skz = tk && (i_instr.op inside {FRU_OP_DEC_SKZ, FRU_OP_INC_SKZ});
    assign wr  = skz || (tk && (i_instr.op inside {FRU_OP_INVERT, FRU_OP_DEC}));
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    // ****************************************
    // properties
    // ****************************************
    a_done_after_take: assert property (tk && i_instr.op != FRU_OP_NOP |=> o_done)
        else $error("done pulse missing");
    a_reg_clear_zero: assert property (tk && i_instr.op == FRU_OP_CLR_REG |=> o_zero && o_result == 8'h00)
        else $error("register clear wrong");
    a_acc_clear_zero: assert property (tk && i_instr.op == FRU_OP_CLR_ACC |=> o_zero && o_acc == 8'h00)
        else $error("accumulator clear wrong");
    a_zero_follows_res: assert property (wr && !skz |=> o_zero == (o_result == 8'h00))
        else $error("zero flag wrong");
    a_acc_gets_res: assert property (wr && !i_instr.dest |=> o_acc == o_result)
        else $error("accumulator not written");
    a_acc_kept_reg: assert property (wr && i_instr.dest |=> $stable(o_acc))
        else $error("accumulator changed");
    a_skip_keep_flag: assert property (skz |=> $stable(o_zero))
        else $error("skip op changed flag");
    a_skip_on_zero: assert property (skz |=> o_skip == (o_result == 8'h00))
        else $error("skip decision wrong");
    a_skip_one_slot: assert property (o_skip |=> !o_skip && !o_done && $stable(o_acc) && $stable(o_zero))
        else $error("skip slot not a nop");
    a_skip_needs_skz: assert property (!skz |=> !o_skip)
        else $error("spurious skip");
    a_nop_quiet: assert property (tk && i_instr.op == FRU_OP_NOP |=>
        !o_done && $stable(o_result) && $stable(o_acc) && $stable(o_zero))
        else $error("nop changed state");
    c_skip: cover property (skz ##1 o_skip);
    c_acc_clear: cover property (tk && i_instr.op == FRU_OP_CLR_ACC);
    c_inv_reg: cover property (tk && i_instr.op == FRU_OP_INVERT && i_instr.dest);
endmodule : fru_chk
bind fru_unit fru_chk u_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_instr_valid(i_instr_valid),
    .i_load_valid(i_load_valid), .i_instr(i_instr), .i_load_addr(i_load_addr), .i_peek_addr(i_peek_addr),
    .i_load_data(i_load_data), .o_acc(o_acc), .o_result(o_result), .o_peek_data(o_peek_data),
    .o_zero(o_zero), .o_skip(o_skip), .o_done(o_done));
`default_nettype wire

// [verification/fru_unit_tb.sv]
// self-checking testbench for the file-register unary operation unit
`timescale 1ns/1ps
`default_nettype none
module fru_unit_tb;
    import fru_pkg::*;
    logic       clk = 1'b0, rst = 1'b1, iv = 1'b0, lv = 1'b0;
    fru_instr_t ins = '0;
    logic [6:0] la = '0, pa = '0;
    logic [7:0] ld = '0, acc, res, pk;
    logic       zero, skip, done;
    int         err_total = 0, checks_done = 0;
    initial forever #12.5 clk = ~clk;
    fru_unit i_dut (.i_clk_sys(clk), .i_rst(rst), .i_instr_valid(iv), .i_instr(ins), .i_load_valid(lv),
        .i_load_addr(la), .i_load_data(ld), .i_peek_addr(pa), .o_acc(acc), .o_zero(zero), .o_skip(skip),
        .o_done(done), .o_result(res), .o_peek_data(pk));
    // ****************************************
    // shared tasks
    // ****************************************
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task load(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        lv <= 1'b1;
        la <= a;
        ld <= d;
        @(posedge clk);
        lv <= 1'b0;
    endtask : load
    task peek(input logic [6:0] a, input logic [7:0] e);
        @(posedge clk);
        pa <= a;
        @(posedge clk);
        #1;
        chk(pk, e);
    endtask : peek
    task st(input logic [7:0] a, input logic z);
        chk(acc, a);
        chk(8'(zero), 8'(z));
    endtask : st
    // a taken skip must swallow the accumulator clear offered right behind it
    task exec(input fru_op_t op, input logic [6:0] a, input logic d, input logic [7:0] r, input logic sk);
        @(posedge clk);
        iv <= 1'b1;
        ins <= '{op, a, d};
        @(posedge clk);
        iv <= sk;
        ins.op <= FRU_OP_CLR_ACC;
        #1;
        chk(8'(done), 8'h01);
        chk(8'(skip), 8'(sk));
        chk(res, r);
        @(posedge clk);
        iv <= 1'b0;
        #1;
        chk(8'(done | skip), 8'h00);
    endtask : exec
    // ****************************************
    // scenarios
    // ****************************************
    task t_invert;
        load(7'h05, 8'h5a);
        load(7'h06, 8'hff);
        exec(FRU_OP_INVERT, 7'h05, 1'b0, 8'ha5, 1'b0);
        st(8'ha5, 1'b0);
        peek(7'h05, 8'h5a);
        exec(FRU_OP_INVERT, 7'h06, 1'b1, 8'h00, 1'b0);
        st(8'ha5, 1'b1);
        peek(7'h06, 8'h00);
        $display("invert test done");
    endtask : t_invert
    task t_clear;
        load(7'h7f, 8'h33);
        exec(FRU_OP_CLR_REG, 7'h7f, 1'b1, 8'h00, 1'b0);
        peek(7'h7f, 8'h00);
        exec(FRU_OP_INVERT, 7'h7f, 1'b0, 8'hff, 1'b0);
        st(8'hff, 1'b0);
        exec(FRU_OP_CLR_ACC, 7'h00, 1'b1, 8'h00, 1'b0);
        st(8'h00, 1'b1);
        $display("clear test done");
    endtask : t_clear
    task t_dec;
        load(7'h00, 8'h01);
        exec(FRU_OP_DEC, 7'h00, 1'b1, 8'h00, 1'b0);
        st(8'h00, 1'b1);
        exec(FRU_OP_DEC, 7'h00, 1'b0, 8'hff, 1'b0);
        st(8'hff, 1'b0);
        $display("decrement test done");
    endtask : t_dec
    task t_skip;
        load(7'h09, 8'h01);
        exec(FRU_OP_DEC_SKZ, 7'h09, 1'b1, 8'h00, 1'b1);
        st(8'hff, 1'b0);
        peek(7'h09, 8'h00);
        load(7'h0a, 8'hff);
        exec(FRU_OP_INC_SKZ, 7'h0a, 1'b0, 8'h00, 1'b1);
        st(8'h00, 1'b0);
        load(7'h0b, 8'h05);
        exec(FRU_OP_INC_SKZ, 7'h0b, 1'b1, 8'h06, 1'b0);
        peek(7'h0b, 8'h06);
        load(7'h0c, 8'h03);
        exec(FRU_OP_DEC_SKZ, 7'h0c, 1'b0, 8'h02, 1'b0);
        st(8'h02, 1'b0);
        $display("skip test done");
    endtask : t_skip
    // a non-zero skip op lets the next op run back to back; a nop after it changes nothing
    task t_order;
        load(7'h12, 8'h07);
        @(posedge clk);
        iv <= 1'b1;
        ins <= '{FRU_OP_INC_SKZ, 7'h12, 1'b0};
        @(posedge clk);
        ins <= '{FRU_OP_CLR_ACC, 7'h12, 1'b0};
        #1;
        st(8'h08, 1'b0);
        @(posedge clk);
        ins.op <= FRU_OP_NOP;
        #1;
        st(8'h00, 1'b1);
        chk(8'(done), 8'h01);
        @(posedge clk);
        iv <= 1'b0;
        #1;
        chk(8'(done | skip), 8'h00);
        chk(res, 8'h00);
        st(8'h00, 1'b1);
        $display("order test done");
    endtask : t_order
    // a register write by an op wins the array port; the preload in that cycle is lost
    task t_collide;
        load(7'h10, 8'h44);
        load(7'h11, 8'h22);
        @(posedge clk);
        iv <= 1'b1;
        ins <= '{FRU_OP_INVERT, 7'h10, 1'b1};
        lv <= 1'b1;
        la <= 7'h11;
        ld <= 8'h77;
        @(posedge clk);
        iv <= 1'b0;
        lv <= 1'b0;
        peek(7'h10, 8'hbb);
        peek(7'h11, 8'h22);
        st(8'h00, 1'b0);
        $display("collide test done");
    endtask : t_collide
    task wrap_up;
        $display("checks_done=%0d err_total=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        #1;
        st(8'h00, 1'b0);
        chk(res, 8'h00);
        chk(pk, 8'h00);
        chk(8'(done | skip), 8'h00);
        t_invert();
        t_clear();
        t_dec();
        t_skip();
        t_order();
        t_collide();
        wrap_up();
    end
endmodule : fru_unit_tb
`default_nettype wire
